// [pbr_fields.sv]
// Behaviour
// - Extended-set field reads constant 111b
// - Port-count field reads 3
// - Legacy speed field reads constant 111b
// - Repeater delay field reads 02h
// - Self-ID link bit is control AND power
// - Link control writable, set by reset
// - Link interface follows power input only
// - Link serviced while powered, control ignored
// - Contender bit copied into self-ID
// - Contender cleared by reset, software sets
module pbr_fields
(
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic       bus_rst,
   input  wire logic       link_power,
   input  wire logic       wr_link_ctrl,
   input  wire logic       wr_contender,
   input  wire logic       wr_data,
   input  wire logic       link_req,
   output logic      [2:0] extended_field,
   output logic      [3:0] num_ports,
   output logic      [2:0] legacy_speed_capability,
   output logic      [3:0] repeater_delay,
   output logic            link_active_control,
   output logic            contender,
   output logic            selfid_link_bit,
   output logic            selfid_contender_bit,
   output logic            link_if_on,
   output logic            link_req_taken
);

   // -------------------------------------------------------------------
   // Writable bit store
   // -------------------------------------------------------------------
   pbr_wr_if wr ();   // Write path bundle

   assign wr.wr_link_ctrl = wr_link_ctrl;
   assign wr.wr_contender = wr_contender;
   assign wr.wr_data      = wr_data;

   pbr_bits u_bits
   (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .wr      (wr)
   );

   // -------------------------------------------------------------------
   // Constant capability fields
   // -------------------------------------------------------------------
   // Registered so outputs come from flops; reload every cycle
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         extended_field          <= pbr_pkg::PBR_EXTENDED_VAL;
         num_ports               <= pbr_pkg::PBR_NUM_PORTS_VAL;
         legacy_speed_capability <= pbr_pkg::PBR_LEGACY_SPD_VAL;
         repeater_delay          <= pbr_pkg::PBR_DELAY_VAL;
      end
      else
      begin
         extended_field          <= pbr_pkg::PBR_EXTENDED_VAL;
         num_ports               <= pbr_pkg::PBR_NUM_PORTS_VAL;
         legacy_speed_capability <= pbr_pkg::PBR_LEGACY_SPD_VAL;
         // Worst-case value; a zero override is software's business
         repeater_delay          <= pbr_pkg::PBR_DELAY_VAL;
      end
   end

   // -------------------------------------------------------------------
   // Readback of writable bits
   // -------------------------------------------------------------------
   // Bus reset is deliberately not a term here: both bits survive it
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         link_active_control <= pbr_pkg::PBR_LINK_CTRL_RST;
         contender           <= pbr_pkg::PBR_CONTENDER_RST;
      end
      else
      begin
         link_active_control <= wr.link_ctrl;
         contender           <= wr.contender;
      end
   end

   // -------------------------------------------------------------------
   // Self-ID packet bits
   // -------------------------------------------------------------------
   // Sampled at each bus reset, when the self-ID packet is built
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         selfid_link_bit      <= 1'b0;
         selfid_contender_bit <= pbr_pkg::PBR_CONTENDER_RST;
      end
      else if (bus_rst)
      begin
         selfid_link_bit      <= wr.link_ctrl & link_power;
         selfid_contender_bit <= wr.contender;
      end
   end

   // -------------------------------------------------------------------
   // Link interface state
   // -------------------------------------------------------------------
   pbr_pkg::pbr_link_e link_state_q;   // Interface state

   // Power input alone decides; link control has no say
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         link_state_q <= pbr_pkg::PBR_LINK_OFF;
      else
      begin
         case (link_state_q)
            pbr_pkg::PBR_LINK_OFF:
               if (link_power)
                  link_state_q <= pbr_pkg::PBR_LINK_ON;
            pbr_pkg::PBR_LINK_ON:
               if (!link_power)
                  link_state_q <= pbr_pkg::PBR_LINK_OFF;
            default:
               link_state_q <= pbr_pkg::PBR_LINK_OFF;
         endcase
      end
   end

   // Status output mirrors state one cycle later
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         link_if_on <= 1'b0;
      else
         link_if_on <= (link_state_q == pbr_pkg::PBR_LINK_ON);
   end

   // -------------------------------------------------------------------
   // Request servicing
   // -------------------------------------------------------------------
   // Requests accepted whenever the interface is on, control ignored
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         link_req_taken <= 1'b0;
      else
         // Served on power state alone; link control is not a term
         link_req_taken <= link_req &&
                           (link_state_q == pbr_pkg::PBR_LINK_ON);
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   // Constant fields: these only trip if someone edits the package
   ext_const_a:    assert property (extended_field == 3'h7)
      else $error("extended field not 111b");
   ports_const_a:  assert property (num_ports == 4'h3)
      else $error("port count not 3");
   speed_const_a:  assert property (
      legacy_speed_capability == 3'h7)
      else $error("legacy speed not 111b");
   delay_const_a:  assert property (repeater_delay == 4'h2)
      else $error("repeater delay not 2");

   // Self-ID bits: loaded on a bus reset edge, frozen otherwise
   selfid_link_a:  assert property (bus_rst |=>
      selfid_link_bit == ($past(wr.link_ctrl) & $past(link_power)))
      else $error("self-ID link bit wrong");
   selfid_hold_a:  assert property (!bus_rst |=>
      $stable(selfid_link_bit) && $stable(selfid_contender_bit))
      else $error("self-ID bits moved without bus reset");
   selfid_cont_a:  assert property (bus_rst |=>
      selfid_contender_bit == $past(wr.contender))
      else $error("self-ID contender bit wrong");

   // Stored bits: written only by their strobe, two cycles to readback
   ctrl_write_a:   assert property (wr_link_ctrl |=> ##1
      link_active_control == $past(wr_data, 2))
      else $error("link control write lost");
   ctrl_hold_a:    assert property (!wr_link_ctrl && bus_rst |=>
      $stable(wr.link_ctrl))
      else $error("link control moved on bus reset");
   cont_write_a:   assert property (wr_contender |=> ##1
      contender == $past(wr_data, 2))
      else $error("contender write lost");
   cont_hold_a:    assert property (!wr_contender && bus_rst |=>
      $stable(wr.contender))
      else $error("contender moved on bus reset");
   cont_set_a:     assert property ($rose(wr.contender) |->
      $past(wr_contender) && $past(wr_data))
      else $error("contender set without write");

   // Interface status output follows the power input, two cycles behind
   link_power_a:   assert property (link_power |=>
      ##1 link_if_on)
      else $error("link state ignores power input");
   link_off_a:     assert property (!link_power |=>
      ##1 !link_if_on)
      else $error("link stays on without power");

   // One cycle of refusal after power-up: the state flop lags the pin
   req_serve_a:    assert property (link_req &&
      link_state_q == pbr_pkg::PBR_LINK_ON |=> link_req_taken)
      else $error("request dropped while powered");
   req_gate_a:     assert property (link_req_taken |->
      $past(link_req) && $past(link_state_q == pbr_pkg::PBR_LINK_ON))
      else $error("request taken while link off");

   // -------------------------------------------------------------------
   // Coverage of the main scenarios
   // -------------------------------------------------------------------
   ctrl_off_c:     cover property (wr_link_ctrl && !wr_data);
   cont_on_c:      cover property (wr_contender && wr_data);
   req_noctl_c:    cover property (link_req_taken && !link_active_control);
   selfid_c:       cover property (bus_rst && link_power);

endmodule

// [pbr_pkg.sv]
package pbr_pkg;

   // -------------------------------------------------------------------
   // Read-only capability fields
   // -------------------------------------------------------------------
   localparam logic [2:0] PBR_EXTENDED_VAL   = 3'h7;  // Extended set present
   localparam logic [3:0] PBR_NUM_PORTS_VAL  = 4'h3;  // Port count reported
   localparam logic [2:0] PBR_LEGACY_SPD_VAL = 3'h7;  // Obsolete speed field
   localparam logic [3:0] PBR_DELAY_VAL      = 4'h2;  // Repeater delay code

   // Repeater delay encoding: base plus step per count, in ns
   localparam int PBR_DELAY_BASE_NS = 144;
   localparam int PBR_DELAY_STEP_NS = 20;

   // -------------------------------------------------------------------
   // Writable bits: reset values and self-ID packet positions
   // -------------------------------------------------------------------
   localparam logic PBR_LINK_CTRL_RST = 1'b1;  // Set by hardware reset
   localparam logic PBR_CONTENDER_RST = 1'b0;  // Clear by hardware reset
   localparam int   PBR_SELFID_L_POS  = 9;     // Link-active bit in self-ID
   localparam int   PBR_SELFID_C_POS  = 20;    // Contender bit in self-ID

   // Link interface state
   typedef enum logic [0:0] {
      PBR_LINK_OFF,
      PBR_LINK_ON
   } pbr_link_e;

endpackage

// [pbr_wr_if.sv]
// -------------------------------------------------------------------
// Software write path into the writable bits
// -------------------------------------------------------------------
interface pbr_wr_if;
   logic wr_link_ctrl;    // Write strobe, link-active control
   logic wr_contender;    // Write strobe, contender bit
   logic wr_data;         // Value written
   logic link_ctrl;       // Stored link-active control
   logic contender;       // Stored contender bit

   modport ctl  (output wr_link_ctrl, output wr_contender,
                 output wr_data, input link_ctrl, input contender);
   modport bits (input wr_link_ctrl, input wr_contender,
                 input wr_data, output link_ctrl, output contender);
endinterface

// [pbr_bits.sv]
// -------------------------------------------------------------------
// Writable bit store, immune to bus reset
// -------------------------------------------------------------------
module pbr_bits
(
   input  wire logic mclk,
   input  wire logic sys_rst,
   pbr_wr_if.bits    wr
);

   logic link_ctrl_q;   // Link-active control
   logic contender_q;   // Contender

   // Link control: hardware reset sets, no bus reset input here at all
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         link_ctrl_q <= pbr_pkg::PBR_LINK_CTRL_RST;
      else if (wr.wr_link_ctrl)
         link_ctrl_q <= wr.wr_data;
   end

   // Contender: only a software write may set it
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         contender_q <= pbr_pkg::PBR_CONTENDER_RST;
      else if (wr.wr_contender)
         contender_q <= wr.wr_data;
   end

   assign wr.link_ctrl = link_ctrl_q;
   assign wr.contender = contender_q;

endmodule

// [pbr_link_model.sv]
// -------------------------------------------------------------------
// Link layer side: power status, requests and delay reckoning
// -------------------------------------------------------------------
module pbr_link_model
(
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic       pwr_cmd,        // Bench asks for link power
   input  wire logic       req_cmd,        // Bench asks for a request
   input  wire logic       fast_only,      // Network has fast links only
   input  wire logic [3:0] repeater_delay, // Field read from the block
   output logic            link_power,
   output logic            link_req,
   output int              delay_ns        // Delay software would assume
);
   timeunit 1ns;
   timeprecision 100ps;

   // Registered like a real link; requests are not gated by power,
   // so the block itself must drop requests made while unpowered
   always @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         link_power <= 1'b0;
         link_req   <= 1'b0;
      end
      else
      begin
         link_power <= pwr_cmd;
         link_req   <= req_cmd;
      end
   end

   // Fast-only networks may take the delay as zero
   always_comb
      delay_ns = fast_only ? 0 :
                 pbr_pkg::PBR_DELAY_BASE_NS +
                 pbr_pkg::PBR_DELAY_STEP_NS * int'(repeater_delay);
endmodule

// [tb.sv]
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
   fail_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
   end end

module tb;
   timeunit 1ns;
   timeprecision 100ps;

   // -------------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------------
   logic       mclk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       bus_rst = 1'b0;
   logic       wr_lc = 1'b0;     // Strobe, link-active control
   logic       wr_cn = 1'b0;     // Strobe, contender
   logic       wr_data = 1'b0;
   logic       pwr_cmd = 1'b0;
   logic       req_cmd = 1'b0;
   logic       fast_only = 1'b0;
   logic       link_power, link_req, lac, cont, sl, sc, lon, taken;
   logic [2:0] ext, spd;
   logic [3:0] nports, dly;
   int         delay_ns, fail_count = 0, checks = 0, cyc = 0, tk = 0, t0;

   pbr_link_model u_link (.mclk(mclk), .sys_rst(sys_rst), .pwr_cmd(pwr_cmd),
      .req_cmd(req_cmd), .fast_only(fast_only), .repeater_delay(dly),
      .link_power(link_power), .link_req(link_req), .delay_ns(delay_ns));

   pbr_fields u_dut (.mclk(mclk), .sys_rst(sys_rst), .bus_rst(bus_rst),
      .link_power(link_power), .wr_link_ctrl(wr_lc), .wr_contender(wr_cn),
      .wr_data(wr_data), .link_req(link_req), .extended_field(ext),
      .num_ports(nports), .legacy_speed_capability(spd),
      .repeater_delay(dly), .link_active_control(lac), .contender(cont),
      .selfid_link_bit(sl), .selfid_contender_bit(sc), .link_if_on(lon),
      .link_req_taken(taken));

   // -------------------------------------------------------------------
   // Clock, accepted-request count and hang guard
   // -------------------------------------------------------------------
   initial forever #4 mclk = ~mclk;

   // Ceiling well above the roughly 120 cycles the tests need; counted
   // at the falling edge, where the one-cycle taken pulse is settled
   always @(negedge mclk)
   begin
      cyc++;
      if (taken === 1'b1) tk++;
      if (cyc == 3000)
      begin
         fail_count++;
         stop_test();
      end
   end

   task automatic stop_test();
      if (fail_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // -------------------------------------------------------------------
   // Access tasks
   // -------------------------------------------------------------------
   // Let n edges pass, then look at settled outputs
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask

   // One-cycle write strobe; both strobes may share wr_data
   task automatic wr(input logic lc, input logic cn, input logic v);
      @(posedge mclk);
      wr_lc <= lc;
      wr_cn <= cn;
      wr_data <= v;
      @(posedge mclk);
      wr_lc <= 1'b0;
      wr_cn <= 1'b0;
      idle(2);
   endtask

   task automatic pulse_bus_rst();
      @(posedge mclk);
      bus_rst <= 1'b1;
      @(posedge mclk);
      bus_rst <= 1'b0;
      idle(2);
   endtask

   task automatic power(input logic p);
      @(posedge mclk);
      pwr_cmd <= p;
      idle(6);
   endtask

   // Back-to-back requests, then the count of those taken
   task automatic reqs(input int n, input int exp);
      t0 = tk;
      @(posedge mclk);
      req_cmd <= 1'b1;
      repeat (n) @(posedge mclk);
      req_cmd <= 1'b0;
      idle(4);
      `CHK("req_taken", exp, tk - t0)
   endtask

   // -------------------------------------------------------------------
   // Tests
   // -------------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      idle(2);
      `CHK("extended", 3'h7, ext)
      `CHK("num_ports", 4'h3, nports)
      `CHK("legacy_speed", 3'h7, spd)
      `CHK("delay_code", 4'h2, dly)
      `CHK("delay_ns", 184, delay_ns)
      @(posedge mclk);
      fast_only <= 1'b1;
      idle(1);
      `CHK("delay_fast", 0, delay_ns)
      `CHK("lac_rst", 1'b1, lac)
      `CHK("cont_rst", 1'b0, cont)
      `CHK("lon_rst", 1'b0, lon)
      `CHK("sl_rst", 1'b0, sl)
      `CHK("sc_rst", 1'b0, sc)
      `CHK("taken_rst", 1'b0, taken)
      // Every control and power pairing into the self-ID
      for (int i = 0; i < 4; i++)
      begin
         wr(1'b1, 1'b0, i[0]);
         power(i[1]);
         pulse_bus_rst();
         `CHK("lac_rd", i[0], lac)
         `CHK("selfid_l", i[0] & i[1], sl)
         `CHK("link_on", i[1], lon)
      end
      // Contender copied, both bits survive bus reset
      wr(1'b0, 1'b1, 1'b1);
      pulse_bus_rst();
      `CHK("cont_rd", 1'b1, cont)
      `CHK("selfid_c", 1'b1, sc)
      `CHK("lac_keep", 1'b1, lac)
      // Control cleared yet powered link still served
      wr(1'b1, 1'b0, 1'b0);
      `CHK("link_on_c0", 1'b1, lon)
      reqs(3, 3);
      power(1'b0);
      reqs(2, 0);
      // Shared strobe, then a second hardware reset
      wr(1'b1, 1'b1, 1'b0);
      `CHK("cont_clr", 1'b0, cont)
      wr(1'b0, 1'b1, 1'b1);
      `CHK("cont_set", 1'b1, cont)
      `CHK("lac_hold", 1'b0, lac)
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      idle(2);
      `CHK("sc_rst2", 1'b0, sc)
      `CHK("lac_rst2", 1'b1, lac)
      `CHK("cont_rst2", 1'b0, cont)
      stop_test();
   end
endmodule
